/* File: sre_cfg.svh */
// constants of the secondary packet parity encoder
`ifndef SRE_CFG_SVH
`define SRE_CFG_SVH
`define SRE_EXT_TYPE 8'h04
`define SRE_OWN_ID_ADDR 20'h00300
`define SRE_FAR_ID_ADDR 20'h00400
`define SRE_ID_BYTES 2'h3
`define SRE_START_SYM 8'h5C
`define SRE_END_SYM 8'hFD
`define SRE_PAYLOAD_BYTES 5'h10
`define SRE_FIFO_DEPTH 32
`define SRE_MODE_ONE_LANE 2'h0
`define SRE_MODE_TWO_LANE 2'h1
`define SRE_MODE_FOUR_LANE 2'h2
`endif

/* File: sre_pkg.sv */
// types of the secondary packet parity encoder
package sre_pkg;
  typedef enum {PKT_IDLE, PKT_SEND} sre_pkt_state_type;
  typedef enum {ID_IDLE, ID_WRITE, ID_READ, ID_DONE} sre_id_state_type;
  typedef struct packed {
    logic [3:0] laneOn;
    logic [3:0] isCtrl;
    logic [3:0][7:0] sym;
  } sre_lane_word_type;
  typedef struct packed {
    sre_pkt_state_type pktState;
    logic pktReady;
    logic extRefused;
    logic [3:0][7:0] hdr;
    logic [15:0][7:0] pay;
    logic [1:0] laneMode;
    logic [5:0] beat;
    sre_id_state_type idState;
    logic [1:0] idIdx;
    logic auxReqValid;
    logic auxReqWrite;
    logic [19:0] auxReqAddr;
    logic [7:0] auxReqData;
    logic extAllowed;
    logic idMismatch;
  } sre_state_type;
endpackage : sre_pkg

/* File: sre_encoder.sv */
// secondary packet parity encoder with lane framing and output fifo
// Behaviour
// - every packet leaving the block carries parity bytes.
// - packet is four header bytes, four header parity, sixteen payload, four payload parity.
// - each lane closes its packet with a parity byte before the end marker.
// - payload bytes past the given length are zeroed before parity is computed.
// - parity comes from a fifteen by thirteen nibble Reed-Solomon code.
// - field is sixteen elements, generator x squared plus alpha4 x plus alpha.
// - two-stage nibble shift register; its final contents are the two parity nibbles.
// - fixed xor equations multiply a nibble by alpha4 and by alpha.
// - nibbles are interleaved across code words before encoding.
// - lanes zero and one pair up, lanes two and three pair up.
// - header low nibble first then high nibble, byte zero then byte one.
// - each lane payload gives two parity nibbles from eight data nibbles.
// - five top payload code word nibbles are zero and never sent.
// - header code word has two data nibbles; eleven zero nibbles never sent.
// - parity covers header and payload of extension packets too.
// - extension packets carry type code 04h in header byte one.
// - own identifier written at 300h..302h, far identifier read at 400h..402h.
// - extension packets are sent only once the far identifier matched.

`include "sre_cfg.svh"

module sre_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } sre_fifo_state_type;
  sre_fifo_state_type st;
  sre_fifo_state_type next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWrite;
  logic doRead;

  always_comb
  begin
    next_st = st;
    inReady = (st.count != (AW+1)'(DEPTH));
    doWrite = inValid && inReady;
    doRead = (st.count != '0) && (!st.outValid || outReady);
    if (outReady)
    begin
      next_st.outValid = 1'b0;
    end
    if (doRead)
    begin
      next_st.outValid = 1'b1;
      next_st.outData = mem[st.rdPtr];
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    if (doWrite)
    begin
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(doWrite) - (AW+1)'(doRead);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (doWrite)
    begin
      mem[st.wrPtr] <= inData;
    end
  end

  assign outValid = st.outValid;
  assign outData = st.outData;
endmodule : sre_fifo

module sre_encoder (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] laneCount,
  input wire logic pktValid,
  output logic pktReady,
  input wire logic pktIsExt,
  input wire logic [3:0][7:0] pktHeader,
  input wire logic [15:0][7:0] pktPayload,
  input wire logic [4:0] pktLength,
  output logic extRefused,
  output logic laneValid,
  input wire logic laneReady,
  output sre_pkg::sre_lane_word_type laneWord,
  input wire logic idStart,
  input wire logic [23:0] ownId,
  input wire logic [23:0] supportedFarId,
  output logic auxReqValid,
  output logic auxReqWrite,
  output logic [19:0] auxReqAddr,
  output logic [7:0] auxReqData,
  input wire logic auxReqDone,
  input wire logic [7:0] auxReadData,
  output logic extAllowed,
  output logic idMismatch
);
  sre_pkg::sre_state_type st;
  sre_pkg::sre_state_type next_st;
  sre_pkg::sre_lane_word_type pushWord;
  logic pushValid;
  logic pushReady;
  logic [3:0][6:0][7:0] unitByte;
  logic [15:0] hdrPar01;
  logic [15:0] hdrPar23;
  logic [15:0] payPar01;
  logic [15:0] payPar23;

  function automatic logic [3:0] gfMulA4(input logic [3:0] c);
    gfMulA4 = {c[3] ^ c[2], c[2] ^ c[1], c[3] ^ c[1] ^ c[0], c[3] ^ c[0]};
  endfunction : gfMulA4

  function automatic logic [3:0] gfMulA(input logic [3:0] c);
    gfMulA = {c[2], c[1], c[3] ^ c[0], c[3]};
  endfunction : gfMulA

  // nibble lfsr; leading zero nibbles leave it at zero, so short code words just start late
  function automatic logic [7:0] rsRemainder(input logic [7:0][3:0] nib);
    logic [3:0] r1;
    logic [3:0] r0;
    logic [3:0] fb;
    r1 = '0;
    r0 = '0;
    for (int i = 7; i >= 0; i--)
    begin
      fb = nib[i] ^ r1;
      r1 = r0 ^ gfMulA4(fb);
      r0 = gfMulA(fb);
    end
    rsRemainder = {r1, r0};
  endfunction : rsRemainder

  // parity of a lane pair: returns {parity byte of lane b, parity byte of lane a}
  function automatic logic [15:0] pairParity(input logic [3:0][7:0] ba, input logic [3:0][7:0] bb);
    logic [7:0][3:0] cw0;
    logic [7:0][3:0] cw1;
    logic [7:0] p0;
    logic [7:0] p1;
    for (int k = 0; k < 4; k++)
    begin
      cw0[7-2*k] = ba[k][3:0];
      cw0[6-2*k] = bb[k][7:4];
      cw1[7-2*k] = ba[k][7:4];
      cw1[6-2*k] = bb[k][3:0];
    end
    p0 = rsRemainder(cw0);
    p1 = rsRemainder(cw1);
    pairParity = {p0[3:0], p1[3:0], p1[7:4], p0[7:4]};
  endfunction : pairParity

  always_comb
  begin
    // header bytes sit in the last slot so the zero nibbles lead the code word
    hdrPar01 = pairParity({st.hdr[0], 24'h0}, {st.hdr[1], 24'h0});
    hdrPar23 = pairParity({st.hdr[2], 24'h0}, {st.hdr[3], 24'h0});
    payPar01 = pairParity(st.pay[3:0], st.pay[7:4]);
    payPar23 = pairParity(st.pay[11:8], st.pay[15:12]);
  end

  // unit i is what lane i carries in four-lane mode
  for (genvar u = 0; u < 4; u++)
  begin : g_unit
    logic [7:0] hdrPb;
    logic [7:0] payPb;
    assign hdrPb = (u == 0) ? hdrPar01[7:0] : (u == 1) ? hdrPar01[15:8] :
                   (u == 2) ? hdrPar23[7:0] : hdrPar23[15:8];
    assign payPb = (u == 0) ? payPar01[7:0] : (u == 1) ? payPar01[15:8] :
                   (u == 2) ? payPar23[7:0] : payPar23[15:8];
    assign unitByte[u] = {payPb, st.pay[4*u+3], st.pay[4*u+2], st.pay[4*u+1], st.pay[4*u],
                          hdrPb, st.hdr[u]};
  end

  // byte that lane L carries at data beat b, units per lane k
  function automatic logic [7:0] laneByte(input logic [3:0][6:0][7:0] ub, input logic [2:0] k,
                                          input logic [1:0] lane, input logic [5:0] b);
    logic [5:0] bb;
    logic [2:0] j;
    logic [2:0] pos;
    logic [2:0] n;
    n = 3'(4 / int'(k));
    if (b < 6'(2 * k))
    begin
      j = 3'(b / 2);
      pos = 3'(b % 2);
    end
    else
    begin
      bb = b - 6'(2 * k);
      j = 3'(bb / 5);
      pos = 3'(2 + bb % 5);
    end
    laneByte = ub[2'(int'(lane) + int'(n) * int'(j))][pos];
  endfunction : laneByte

  always_comb
  begin
    logic [2:0] k;
    logic [5:0] lastBeat;
    k = (st.laneMode == `SRE_MODE_FOUR_LANE) ? 3'h1 : (st.laneMode == `SRE_MODE_TWO_LANE) ? 3'h2 : 3'h4;
    lastBeat = 6'(7 * k + 1);
    next_st = st;
    next_st.extRefused = 1'b0;
    pushValid = (st.pktState == sre_pkg::PKT_SEND);
    pushWord.laneOn = (k == 3'h1) ? 4'hF : (k == 3'h2) ? 4'h3 : 4'h1;
    pushWord.isCtrl = ((st.beat == 6'h0) || (st.beat == lastBeat)) ? pushWord.laneOn : 4'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (!pushWord.laneOn[l])
      begin
        pushWord.sym[l] = 8'h00;
      end
      else if (st.beat == 6'h0)
      begin
        pushWord.sym[l] = `SRE_START_SYM;
      end
      else if (st.beat == lastBeat)
      begin
        pushWord.sym[l] = `SRE_END_SYM;
      end
      else
      begin
        pushWord.sym[l] = laneByte(unitByte, k, 2'(l), st.beat - 6'h1);
      end
    end
    case (st.pktState)
      sre_pkg::PKT_IDLE:
      begin
        if (pktValid && st.pktReady)
        begin
          if (pktIsExt && !st.extAllowed)
          begin
            next_st.extRefused = 1'b1;
          end
          else
          begin
            next_st.pktState = sre_pkg::PKT_SEND;
            next_st.hdr = pktHeader;
            if (pktIsExt)
            begin
              next_st.hdr[1] = `SRE_EXT_TYPE;
            end
            for (int i = 0; i < 16; i++)
            begin
              next_st.pay[i] = (5'(i) < pktLength) ? pktPayload[i] : 8'h00;
            end
            next_st.laneMode = laneCount;
            next_st.beat = 6'h0;
          end
        end
      end
      sre_pkg::PKT_SEND:
      begin
        if (pushReady)
        begin
          next_st.beat = st.beat + 6'h1;
          if (st.beat == lastBeat)
          begin
            next_st.pktState = sre_pkg::PKT_IDLE;
          end
        end
      end
      default:
      begin
        next_st.pktState = sre_pkg::PKT_IDLE;
      end
    endcase
    next_st.pktReady = (next_st.pktState == sre_pkg::PKT_IDLE);
    // identifier exchange over the auxiliary request port
    case (st.idState)
      sre_pkg::ID_IDLE, sre_pkg::ID_DONE:
      begin
        if (idStart)
        begin
          next_st.idState = sre_pkg::ID_WRITE;
          next_st.idIdx = 2'h0;
          next_st.extAllowed = 1'b0;
          next_st.idMismatch = 1'b0;
          next_st.auxReqValid = 1'b1;
          next_st.auxReqWrite = 1'b1;
          next_st.auxReqAddr = `SRE_OWN_ID_ADDR;
          next_st.auxReqData = ownId[7:0];
        end
      end
      sre_pkg::ID_WRITE:
      begin
        if (auxReqDone)
        begin
          next_st.idIdx = st.idIdx + 2'h1;
          next_st.auxReqAddr = st.auxReqAddr + 20'h1;
          next_st.auxReqData = ownId[8*(int'(st.idIdx)+1) +: 8];
          if (st.idIdx == `SRE_ID_BYTES - 2'h1)
          begin
            next_st.idState = sre_pkg::ID_READ;
            next_st.idIdx = 2'h0;
            next_st.auxReqWrite = 1'b0;
            next_st.auxReqAddr = `SRE_FAR_ID_ADDR;
            next_st.auxReqData = 8'h00;
          end
        end
      end
      sre_pkg::ID_READ:
      begin
        if (auxReqDone)
        begin
          if (auxReadData != supportedFarId[8*int'(st.idIdx) +: 8])
          begin
            next_st.idMismatch = 1'b1;
          end
          next_st.idIdx = st.idIdx + 2'h1;
          next_st.auxReqAddr = st.auxReqAddr + 20'h1;
          if (st.idIdx == `SRE_ID_BYTES - 2'h1)
          begin
            next_st.idState = sre_pkg::ID_DONE;
            next_st.auxReqValid = 1'b0;
            next_st.extAllowed = !next_st.idMismatch;
          end
        end
      end
      default:
      begin
        next_st.idState = sre_pkg::ID_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{pktState: sre_pkg::PKT_IDLE, idState: sre_pkg::ID_IDLE, pktReady: 1'b1, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  sre_fifo #(
    .WIDTH($bits(sre_pkg::sre_lane_word_type)),
    .DEPTH(`SRE_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(laneValid),
    .outReady(laneReady),
    .outData(laneWord)
  );

  assign pktReady = st.pktReady;
  assign extRefused = st.extRefused;
  assign auxReqValid = st.auxReqValid;
  assign auxReqWrite = st.auxReqWrite;
  assign auxReqAddr = st.auxReqAddr;
  assign auxReqData = st.auxReqData;
  assign extAllowed = st.extAllowed;
  assign idMismatch = st.idMismatch;
endmodule : sre_encoder

/* File: sre_encoder_assertions.sv */
// assertion checker for the secondary packet parity encoder
module sre_encoder_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pktValid,
  input wire logic pktReady,
  input wire logic pktIsExt,
  input wire logic extRefused,
  input wire logic laneValid,
  input wire logic laneReady,
  input wire sre_pkg::sre_lane_word_type laneWord,
  input wire logic idStart,
  input wire logic [23:0] ownId,
  input wire logic auxReqValid,
  input wire logic auxReqWrite,
  input wire logic [19:0] auxReqAddr,
  input wire logic [7:0] auxReqData,
  input wire logic auxReqDone,
  input wire logic extAllowed,
  input wire logic idMismatch
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_refuse;
    pktValid && pktReady && pktIsExt && !extAllowed |=> extRefused && pktReady;
  endproperty
  a_refuse: assert property (p_refuse) else $error("extension packet not refused");
  property p_refuse_pulse;
    extRefused |-> $past(pktValid && pktIsExt && !extAllowed) ##1 !extRefused;
  endproperty
  a_refuse_pulse: assert property (p_refuse_pulse) else $error("refuse pulse wrong");
  property p_busy;
    pktValid && pktReady && !pktIsExt |=> !pktReady [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("ready too early after accept");
  property p_out;
    pktValid && pktReady && !pktIsExt |-> ##[2:60] laneValid;
  endproperty
  a_out: assert property (p_out) else $error("no lane word after accept");
  property p_stall;
    laneValid && !laneReady |=> laneValid && $stable(laneWord);
  endproperty
  a_stall: assert property (p_stall) else $error("lane word lost in stall");
  property p_ctrl;
    laneValid && laneWord.isCtrl[0] |-> laneWord.sym[0] == 8'h5C || laneWord.sym[0] == 8'hFD;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("bad framing symbol");
  property p_idle_lane;
    laneValid && !laneWord.laneOn[3] |-> laneWord.sym[3] == 8'h00 && !laneWord.isCtrl[3];
  endproperty
  a_idle_lane: assert property (p_idle_lane) else $error("inactive lane not quiet");
  property p_aux_start;
    idStart && !auxReqValid |=> auxReqValid && auxReqWrite && auxReqAddr == 20'h00300 && auxReqData == ownId[7:0];
  endproperty
  a_aux_start: assert property (p_aux_start) else $error("first id write wrong");
  property p_aux_hold;
    auxReqValid && !auxReqDone |=> auxReqValid && $stable(auxReqAddr);
  endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("aux request dropped");
  property p_aux_turn;
    auxReqDone && auxReqWrite && auxReqAddr == 20'h00302 |=> auxReqValid && !auxReqWrite && auxReqAddr == 20'h00400;
  endproperty
  a_aux_turn: assert property (p_aux_turn) else $error("read phase start wrong");
  property p_allow;
    $rose(extAllowed) |-> !auxReqValid && !idMismatch;
  endproperty
  a_allow: assert property (p_allow) else $error("allowed without match");
endmodule : sre_encoder_assertions

bind sre_encoder sre_encoder_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .pktValid(pktValid),
  .pktReady(pktReady), .pktIsExt(pktIsExt), .extRefused(extRefused), .laneValid(laneValid),
  .laneReady(laneReady), .laneWord(laneWord), .idStart(idStart), .ownId(ownId), .auxReqValid(auxReqValid),
  .auxReqWrite(auxReqWrite), .auxReqAddr(auxReqAddr), .auxReqData(auxReqData), .auxReqDone(auxReqDone),
  .extAllowed(extAllowed), .idMismatch(idMismatch));

/* File: sre_sink_model.sv */
// far side model: lane sink with stalls and identifier replier
module sre_sink_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [23:0] farId,
  input wire logic auxReqValid,
  input wire logic auxReqWrite,
  input wire logic [19:0] auxReqAddr,
  input wire logic [7:0] auxReqData,
  output logic laneReady,
  output logic auxReqDone,
  output logic [7:0] auxReadData,
  output logic [23:0] gotOwnId
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt;
  logic [1:0] ph;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cnt, ph, laneReady, auxReqDone, auxReadData, gotOwnId} <= '0;
    end
    else
    begin
      ph <= ph + 2'h1;
      // takes words without checking parity, stalling one cycle in four
      laneReady <= !hold && ph != 2'h0;
      auxReqDone <= 1'b0;
      auxReadData <= ~auxReadData;
      if (auxReqValid && !auxReqDone)
      begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3)
        begin
          auxReqDone <= 1'b1;
          if (auxReqWrite)
            gotOwnId[8*auxReqAddr[1:0]+:8] <= auxReqData;
          else
            auxReadData <= farId[8*auxReqAddr[1:0]+:8];
        end
      end
    end
  end
endmodule : sre_sink_model

/* File: sre_encoder_test.sv */
// self-checking testbench of the secondary packet parity encoder
module sre_encoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_n = 0, pktValid = 0, pktIsExt = 0, idStart = 0, hold = 0;
  logic [1:0] laneCount = 0;
  logic [3:0][7:0] pktHeader = '0;
  logic [15:0][7:0] pktPayload = '0;
  logic [4:0] pktLength = 0;
  logic [23:0] ownId = 24'hA1B2C3, supportedFarId = 24'h3C5A96, farId = 24'h3C5A96;
  wire pktReady, extRefused, laneValid, laneReady, auxReqValid, auxReqWrite, auxReqDone, extAllowed, idMismatch;
  wire [19:0] auxReqAddr;
  wire [7:0] auxReqData, auxReadData;
  wire [23:0] gotOwnId;
  wire sre_pkg::sre_lane_word_type laneWord;
  int miscompares = 0, n_checks = 0;
  sre_pkg::sre_lane_word_type expQ[$], gotQ[$];
  logic [7:0] hb[4], db[16], pb[8];
  sre_encoder dut (.core_clk(core_clk), .rst_n(rst_n), .laneCount(laneCount), .pktValid(pktValid),
    .pktReady(pktReady), .pktIsExt(pktIsExt), .pktHeader(pktHeader), .pktPayload(pktPayload),
    .pktLength(pktLength), .extRefused(extRefused), .laneValid(laneValid), .laneReady(laneReady),
    .laneWord(laneWord), .idStart(idStart), .ownId(ownId), .supportedFarId(supportedFarId),
    .auxReqValid(auxReqValid), .auxReqWrite(auxReqWrite), .auxReqAddr(auxReqAddr), .auxReqData(auxReqData),
    .auxReqDone(auxReqDone), .auxReadData(auxReadData), .extAllowed(extAllowed), .idMismatch(idMismatch));
  sre_sink_model model (.core_clk(core_clk), .rst_n(rst_n), .hold(hold), .farId(farId),
    .auxReqValid(auxReqValid), .auxReqWrite(auxReqWrite), .auxReqAddr(auxReqAddr), .auxReqData(auxReqData),
    .laneReady(laneReady), .auxReqDone(auxReqDone), .auxReadData(auxReadData), .gotOwnId(gotOwnId));
  initial forever #10 core_clk = ~core_clk;
  always @(negedge core_clk) if (laneValid === 1'b1 && laneReady === 1'b1) gotQ.push_back(laneWord);
  task tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  function automatic logic [3:0] m4(logic [3:0] c);
    return {c[3]^c[2], c[2]^c[1], c[3]^c[1]^c[0], c[3]^c[0]};
  endfunction : m4
  function automatic logic [7:0] rs(logic [31:0] s, int n);
    logic [3:0] r1 = 0, r0 = 0, fb;
    for (int i = 2*n-1; i >= 0; i--)
    begin
      fb = s[4*i+:4] ^ r1;
      r1 = r0 ^ m4(fb);
      r0 = {fb[2], fb[1], fb[3]^fb[0], fb[3]};
    end
    return {r1, r0};
  endfunction : rs
  task automatic pair(input int p);
    logic [31:0] c0 = 0, c1 = 0;
    logic [7:0] r0, r1;
    r0 = rs({hb[p][3:0], hb[p+1][7:4]}, 1);
    r1 = rs({hb[p][7:4], hb[p+1][3:0]}, 1);
    pb[p] = {r1[7:4], r0[7:4]};
    pb[p+1] = {r0[3:0], r1[3:0]};
    for (int k = 0; k < 4; k++)
    begin
      c0 = {c0[23:0], db[4*p+k][3:0], db[4*p+4+k][7:4]};
      c1 = {c1[23:0], db[4*p+k][7:4], db[4*p+4+k][3:0]};
    end
    r0 = rs(c0, 4);
    r1 = rs(c1, 4);
    pb[4+p] = {r1[7:4], r0[7:4]};
    pb[5+p] = {r0[3:0], r1[3:0]};
  endtask : pair
  task automatic send(input logic [1:0] lc, input int len, input int sd, input logic ext);
    int nl;
    logic [7:0] ln[4][$];
    sre_pkg::sre_lane_word_type w = '0;
    nl = lc == 2'h2 ? 4 : lc == 2'h1 ? 2 : 1;
    for (int i = 0; i < 16; i++)
    begin
      pktPayload[i] = 8'(29*i + sd*7 + 1);
      db[i] = i < len ? pktPayload[i] : 8'h00;
      if (i < 4) pktHeader[i] = 8'(37*i + sd*11 + 5);
      if (i < 4) hb[i] = pktHeader[i];
    end
    if (ext) hb[1] = 8'h04;
    pair(0);
    pair(2);
    for (int l = 0; l < nl; l++)
    begin
      for (int u = l; u < 4; u += nl) ln[l].push_back(hb[u]);
      for (int u = l; u < 4; u += nl) ln[l].push_back(pb[u]);
      for (int u = l; u < 4; u += nl) ln[l] = {ln[l], db[4*u], db[4*u+1], db[4*u+2], db[4*u+3], pb[4+u]};
      w.sym[l] = 8'h5C;
    end
    if (nl == 2) for (int l = 0; l < 2; l++) ln[l] = {ln[l][0], ln[l][2], ln[l][1], ln[l][3], ln[l][4:13]};
    if (nl == 1) ln[0] = {ln[0][0], ln[0][4], ln[0][1], ln[0][5], ln[0][2], ln[0][6], ln[0][3], ln[0][7], ln[0][8:27]};
    w.laneOn = 4'((1 << nl) - 1);
    w.isCtrl = w.laneOn;
    expQ.push_back(w);
    w.isCtrl = 4'h0;
    foreach (ln[0][j])
    begin
      for (int l = 0; l < nl; l++) w.sym[l] = ln[l][j];
      expQ.push_back(w);
    end
    w.isCtrl = w.laneOn;
    for (int l = 0; l < nl; l++) w.sym[l] = 8'hFD;
    expQ.push_back(w);
    laneCount = lc;
    pktIsExt = ext;
    pktLength = 5'(len);
    pktValid = 1;
    for (int i = 0; pktReady !== 1'b1; i++)
    begin
      tick(1);
      if (i == 400) chk(0, "packet never taken");
      if (i == 400) tally_and_finish();
    end
    tick(1);
    pktValid = 0;
    tick(1);
  endtask : send
  task automatic drain(input string nm);
    for (int i = 0; gotQ.size() < expQ.size(); i++)
    begin
      tick(1);
      if (i == 2000) chk(0, "lane words missing");
      if (i == 2000) tally_and_finish();
    end
    tick(5);
    chk(gotQ.size() == expQ.size(), "extra lane words");
    foreach (expQ[i]) chk(gotQ[i] === expQ[i], nm);
    gotQ = {};
    expQ = {};
  endtask : drain
  task t_refuse;
    pktIsExt = 1;
    pktValid = 1;
    tick(1);
    pktValid = 0;
    chk(extRefused === 1'b1 && pktReady === 1'b1, "no refuse pulse");
    tick(1);
    chk(extRefused === 1'b0, "refuse pulse too long");
    tick(30);
    chk(gotQ.size() == 0, "refused packet sent");
  endtask : t_refuse
  task t_id(input logic [23:0] far, input logic ok);
    farId = far;
    idStart = 1;
    tick(1);
    idStart = 0;
    for (int i = 0; i <= 200 && auxReqValid !== 1'b0; i++) tick(1);
    if (auxReqValid !== 1'b0)
    begin
      chk(0, "id exchange never ended");
      tally_and_finish();
    end
    tick(2);
    chk(gotOwnId === ownId, "own id writes");
    chk(extAllowed === ok && idMismatch === !ok, "id verdict");
  endtask : t_id
  task t_fill;
    hold = 1;
    repeat (4) send(2'h2, 16, 9, 0);
    tick(10);
    chk(pktReady === 1'b0 && laneValid === 1'b1, "full fifo no backpressure");
    hold = 0;
    drain("fill and drain");
  endtask : t_fill
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1;
    chk(pktReady === 1'b1 && laneValid === 1'b0 && auxReqValid === 1'b0 && extAllowed === 1'b0, "reset");
    chk(rs(32'hFEDCBA98, 4) === 8'h22 && rs(32'h98321754, 4) === 8'h8F, "reference code");
    t_refuse();
    t_id(24'h005A96, 0);
    t_id(24'h3C5A96, 1);
    send(2'h2, 16, 1, 0);
    drain("four lanes");
    send(2'h1, 5, 2, 1);
    drain("two lanes");
    send(2'h0, 0, 3, 0);
    drain("one lane");
    send(2'h3, 16, 4, 1);
    drain("mode three");
    t_fill();
    tally_and_finish();
  end
endmodule : sre_encoder_test
